// File: rtl/sdc_pkg.sv
// package for the sdram host controller: register map, timing and command codes
package sdc_pkg;
  // ----------------------------------------------------------------
  // clock and time figures
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int POWERUP_US = 100;
  localparam int POWERUP_CYC = (POWERUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REFRESH_MS = 64;
  localparam int REFRESH_ROWS = 8192;
  localparam int REFRESH_CYC = (REFRESH_MS * 1000000 / CLK_PERIOD_NS) / REFRESH_ROWS;
  localparam int INIT_REFRESHES = 8;
  // cycle figures at cas latency three, the worst case, used for both latencies
  localparam int T_MODE_CYC = 2;
  localparam int T_ACT_RW_CYC = 3;
  localparam int T_ROW_CYCLE_CYC = 10;
  localparam int T_ACT_PRE_CYC = 7;
  localparam int T_PRE_ACT_CYC = 3;
  localparam int T_WRITE_PRE_CYC = 2;
  // ----------------------------------------------------------------
  // apb register map
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_RDATA = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_MODE = 8'h14;
  // mode word after reset: burst length 1, sequential, cas latency 3, single write
  localparam logic [12:0] MODE_RESET = 13'h0230;
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_WRITE_BIT = 1;
  // ----------------------------------------------------------------
  // sdram commands as {cs_b, ras_b, cas_b, we_b}
  // ----------------------------------------------------------------
  localparam logic [3:0] CMD_INHIBIT = 4'hf;
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_ACTIVE = 4'h3;
  localparam logic [3:0] CMD_READ = 4'h5;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_PRECHARGE = 4'h2;
  localparam logic [3:0] CMD_REFRESH = 4'h1;
  localparam logic [3:0] CMD_LOAD_MODE = 4'h0;
endpackage

// File: rtl/sdc_wait_timer.sv
// down-counter that spaces sdram commands by a loaded number of cycles
`timescale 1ns/1ps
module sdc_wait_timer
  import sdc_pkg::*;
#(
  parameter int WIDTH = 17
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // load side
  input wire logic load,
  input wire logic [WIDTH-1:0] count,
  // state
  output logic done
);
  logic [WIDTH-1:0] remain_q;

  // a load of n gives done again n+1 cycles after the load cycle
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      remain_q <= '0;
    else if (load)
      remain_q <= count;
    else if (remain_q != '0)
      remain_q <= remain_q - 1'b1;
  end

  assign done = (remain_q == '0) && !load;
endmodule

// File: rtl/sdc_host.sv
// host controller that powers up, programs and accesses one sdram
//
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/1ps
module sdc_host
  import sdc_pkg::*;
#(
  parameter int DATA_WIDTH = 16,
  parameter int POWERUP_CYCLES = POWERUP_CYC
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // sdram command pins
  output logic sdClkEn_q,
  output logic sdChipSel_b_q,
  output logic sdRowStrobe_b_q,
  output logic sdColStrobe_b_q,
  output logic sdWriteEn_b_q,
  output logic [1:0] sdBank_q,
  output logic [12:0] sdAddr_q,
  output logic sdMask_q,
  // sdram data pins
  input wire logic [DATA_WIDTH-1:0] sdDataIn,
  output logic [DATA_WIDTH-1:0] sdDataOut_q,
  output logic sdDataOe_b_q
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  typedef enum {
    ST_POWERUP, ST_INIT_PRE, ST_INIT_REF, ST_INIT_MODE, ST_IDLE,
    ST_REFRESH, ST_ACTIVE, ST_COLUMN, ST_READ_WAIT, ST_PRECHARGE
  } sdc_state_t;

  sdc_state_t stateQ;
  logic [3:0] cmdQ;
  logic [3:0] refCountQ;
  logic [16:0] waitCount;
  logic waitLoad;
  logic waitDone;
  logic [11:0] refTimerQ;
  logic refDueQ;
  logic goQ;
  logic writeQ;
  logic busyQ;
  logic readyFlagQ;
  logic [26:0] accAddrQ;
  logic [DATA_WIDTH-1:0] wdataQ;
  logic [DATA_WIDTH-1:0] rdataQ;
  logic [12:0] modeQ;
  logic [2:0] rdPipeQ;
  logic apbWrite;
  logic goTaken;

  assign apbWrite = psel && penable && pwrite;
  // go is only taken when the sequencer really starts; clearing it earlier would drop the access
  assign goTaken = goQ && (stateQ == ST_IDLE) && waitDone && !refDueQ;

  // command spacing timer, shared by every step of the sequence
  sdc_wait_timer #(.WIDTH(17)) uTimer (
    .clk(clk),
    .rst_b(rst_b),
    .load(waitLoad),
    .count(waitCount),
    .done(waitDone)
  );

  // ----------------------------------------------------------------
  // apb registers
  // ----------------------------------------------------------------
  // one wait-free access phase; unmapped offsets read zero and flag an error
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && (paddr > REG_MODE || paddr[1:0] != 2'h0);
      case (paddr)
        REG_ADDR: prdata <= {5'h00, accAddrQ};
        REG_WDATA: prdata <= 32'(wdataQ);
        REG_RDATA: prdata <= 32'(rdataQ);
        REG_STATUS: prdata <= {28'h0000000, 1'b0, readyFlagQ, busyQ, goQ};
        REG_MODE: prdata <= {19'h00000, modeQ};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // software-written access registers; the mode word is used by the running init's mode load, and reset restores MODE_RESET
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      accAddrQ <= '0;
      wdataQ <= '0;
      modeQ <= MODE_RESET;
      writeQ <= 1'b0;
    end
    else if (apbWrite && pready)
    begin
      if (paddr == REG_ADDR)
        accAddrQ <= pwdata[26:0];
      if (paddr == REG_WDATA)
        wdataQ <= pwdata[DATA_WIDTH-1:0];
      if (paddr == REG_MODE)
        modeQ <= pwdata[12:0];
      if (paddr == REG_CTRL)
        writeQ <= pwdata[CTRL_WRITE_BIT];
    end
  end

  // go is set by software and cleared when the access starts
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      goQ <= 1'b0;
    else if (apbWrite && pready && paddr == REG_CTRL && pwdata[CTRL_GO_BIT])
      goQ <= 1'b1;
    else if (goTaken)
      goQ <= 1'b0;
  end

  // ----------------------------------------------------------------
  // refresh pacing
  // ----------------------------------------------------------------
  // set wins over clear so a due refresh is never dropped
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      refTimerQ <= '0;
      refDueQ <= 1'b0;
    end
    else
    begin
      if (refTimerQ == 12'(REFRESH_CYC - 1))
      begin
        refTimerQ <= '0;
        refDueQ <= readyFlagQ;
      end
      else
      begin
        refTimerQ <= refTimerQ + 1'b1;
        if (stateQ == ST_REFRESH)
          refDueQ <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // command sequencer
  // ----------------------------------------------------------------
  // every command is held for one cycle, then NOP while the timer runs
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stateQ <= ST_POWERUP;
      cmdQ <= CMD_INHIBIT;
      refCountQ <= '0;
      busyQ <= 1'b0;
      readyFlagQ <= 1'b0;
      rdPipeQ <= '0;
      rdataQ <= '0;
      sdBank_q <= 2'h0;
      sdAddr_q <= 13'h0000;
      sdDataOut_q <= '0;
      sdDataOe_b_q <= 1'b1;
      waitLoad <= 1'b1;
      waitCount <= 17'(POWERUP_CYCLES);
    end
    else
    begin
      cmdQ <= CMD_NOP;
      waitLoad <= 1'b0;
      sdDataOe_b_q <= 1'b1;
      rdPipeQ <= {rdPipeQ[1:0], 1'b0};
      case (stateQ)
        ST_POWERUP:
        begin
          if (waitDone)
          begin
            cmdQ <= CMD_PRECHARGE;
            sdAddr_q <= 13'h0400; // all banks
            waitLoad <= 1'b1;
            waitCount <= 17'(T_PRE_ACT_CYC);
            refCountQ <= '0;
            stateQ <= ST_INIT_REF;
          end
        end
        ST_INIT_REF:
        begin
          if (waitDone)
          begin
            if (refCountQ == 4'(INIT_REFRESHES))
            begin
              cmdQ <= CMD_LOAD_MODE;
              sdBank_q <= 2'h0;
              sdAddr_q <= modeQ;
              waitLoad <= 1'b1;
              waitCount <= 17'(T_MODE_CYC);
              stateQ <= ST_INIT_MODE;
            end
            else
            begin
              cmdQ <= CMD_REFRESH;
              refCountQ <= refCountQ + 1'b1;
              waitLoad <= 1'b1;
              waitCount <= 17'(T_ROW_CYCLE_CYC);
            end
          end
        end
        ST_INIT_MODE:
        begin
          if (waitDone)
          begin
            readyFlagQ <= 1'b1;
            stateQ <= ST_IDLE;
          end
        end
        ST_IDLE:
        begin
          if (waitDone && refDueQ)
          begin
            cmdQ <= CMD_REFRESH;
            waitLoad <= 1'b1;
            waitCount <= 17'(T_ROW_CYCLE_CYC);
            stateQ <= ST_REFRESH;
          end
          else if (waitDone && goQ)
          begin
            cmdQ <= CMD_ACTIVE;
            busyQ <= 1'b1;
            sdBank_q <= accAddrQ[26:25];
            sdAddr_q <= accAddrQ[24:12];
            waitLoad <= 1'b1;
            waitCount <= 17'(T_ACT_RW_CYC);
            stateQ <= ST_ACTIVE;
          end
        end
        ST_REFRESH:
          stateQ <= ST_IDLE;
        ST_ACTIVE:
        begin
          if (waitDone)
          begin
            // a10 stays low: no auto precharge, so write recovery before active never arises
            sdAddr_q <= {2'h0, 1'b0, accAddrQ[9:0]};
            waitLoad <= 1'b1;
            if (writeQ)
            begin
              cmdQ <= CMD_WRITE;
              sdDataOut_q <= wdataQ;
              sdDataOe_b_q <= 1'b0;
              // row must stay open the longer of tras and write-to-precharge
              waitCount <= 17'(T_ACT_PRE_CYC - T_ACT_RW_CYC);
              stateQ <= ST_PRECHARGE;
            end
            else
            begin
              cmdQ <= CMD_READ;
              rdPipeQ[0] <= 1'b1;
              waitCount <= 17'(T_ACT_PRE_CYC - T_ACT_RW_CYC);
              stateQ <= ST_READ_WAIT;
            end
          end
        end
        ST_READ_WAIT:
        begin
          // latency 3: the word stands on the pins at the third edge after the read
          if (rdPipeQ[2])
            stateQ <= ST_COLUMN;
        end
        ST_COLUMN:
        begin
          // the device runs on this clock and holds its word one cycle only,
          // so it is taken straight off the pins; a synchroniser would lose it
          rdataQ <= sdDataIn;
          stateQ <= ST_PRECHARGE;
        end
        ST_PRECHARGE:
        begin
          if (waitDone)
          begin
            cmdQ <= CMD_PRECHARGE;
            sdAddr_q <= 13'h0400;
            waitLoad <= 1'b1;
            waitCount <= 17'(T_PRE_ACT_CYC + T_ROW_CYCLE_CYC);
            busyQ <= 1'b0;
            stateQ <= ST_IDLE;
          end
        end
        default:
          stateQ <= ST_POWERUP;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pin outputs
  // ----------------------------------------------------------------
  // clock enable stays high and mask stays high until init ends; commands leave as registered pins
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sdClkEn_q <= 1'b1;
      sdMask_q <= 1'b1;
    end
    else
    begin
      sdClkEn_q <= 1'b1;
      sdMask_q <= !readyFlagQ;
    end
  end

  assign sdChipSel_b_q = cmdQ[3];
  assign sdRowStrobe_b_q = cmdQ[2];
  assign sdColStrobe_b_q = cmdQ[1];
  assign sdWriteEn_b_q = cmdQ[0];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_INIT_NOP: assert property (@(posedge clk) disable iff (!rst_b)
    (stateQ == ST_POWERUP) |-> (cmdQ == CMD_NOP || cmdQ == CMD_INHIBIT))
    else $error("command issued during power-up wait");
  AST_MODE_IDLE: assert property (@(posedge clk) disable iff (!rst_b)
    (cmdQ == CMD_LOAD_MODE) |=> (cmdQ == CMD_NOP) [*2])
    else $error("command too soon after mode load");
  AST_ACT_RW: assert property (@(posedge clk) disable iff (!rst_b)
    (cmdQ == CMD_ACTIVE) |=> (cmdQ == CMD_NOP) [*2])
    else $error("column command too soon after active");
  AST_REF_GAP: assert property (@(posedge clk) disable iff (!rst_b)
    (cmdQ == CMD_REFRESH) |=> (cmdQ != CMD_REFRESH && cmdQ != CMD_ACTIVE) [*8]
    ##1 (cmdQ != CMD_REFRESH && cmdQ != CMD_ACTIVE))
    else $error("refresh spacing too short");
  AST_ACT_PRE: assert property (@(posedge clk) disable iff (!rst_b)
    (cmdQ == CMD_ACTIVE) |=> (cmdQ != CMD_PRECHARGE) [*6])
    else $error("precharge too soon after active");
  AST_PRE_ACT: assert property (@(posedge clk) disable iff (!rst_b)
    (cmdQ == CMD_PRECHARGE) |=> (cmdQ != CMD_ACTIVE) [*3])
    else $error("active too soon after precharge");
  AST_WR_PRE: assert property (@(posedge clk) disable iff (!rst_b)
    (cmdQ == CMD_WRITE) |=> (cmdQ != CMD_PRECHARGE) [*2])
    else $error("precharge too soon after write data");
  AST_MODE_FIRST: assert property (@(posedge clk) disable iff (!rst_b)
    (cmdQ == CMD_ACTIVE) |-> readyFlagQ)
    else $error("access before mode load");
  AST_CKE: assert property (@(posedge clk) disable iff (!rst_b)
    !readyFlagQ |-> (sdClkEn_q && sdMask_q))
    else $error("clock enable or mask low during init");
endmodule

// File: bench/sdc_sdram_model.sv
// behavioural sdram device on the controller pins, with command spacing checks
`timescale 1ns/1ps
module sdc_sdram_model
  import sdc_pkg::*;
#(
  parameter int POWERUP = 20
)
(
  // clock and power state
  input wire logic clk,
  input wire logic rst_b,
  // command pins
  input wire logic clkEn,
  input wire logic chipSel_b,
  input wire logic rowStrobe_b,
  input wire logic colStrobe_b,
  input wire logic writeEn_b,
  input wire logic [1:0] bank,
  input wire logic [12:0] addr,
  input wire logic mask,
  // data pins
  input wire logic [15:0] dataIn,
  input wire logic dataOe_b,
  output logic [15:0] dataOut,
  // observations for the bench
  output int badCnt,
  output int refCnt,
  output logic [12:0] modeReg
);
  // ------------------------------------------------------------
  // storage and timing state
  // ------------------------------------------------------------
  logic [15:0] mem [logic [26:0]];
  logic [15:0] slotData [8];
  logic [7:0] slotVal;
  logic [12:0] openRow [4];
  logic [3:0] isOpen;
  logic [26:0] key;
  logic [3:0] cmd;
  logic allPre, modeOk, maskPrev;
  int lastAct [4];
  int cyc, lastActAny, lastPre, lastRef, lastWr, modeAt, cl;
  localparam logic [3:0] CMD_BURST_STOP = 4'h6;

  task automatic fail(input string s);
    badCnt++;
    $display("BAD timing %s expected legal seen cycle %0d", s, cyc);
  endtask

  // inputs sampled on the rising edge only; timing state and counters are lost on controller reset, stored words are kept
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cyc = 0;
      lastActAny = -99;
      lastPre = -99;
      lastRef = -99;
      lastWr = -99;
      modeAt = -99;
      lastAct = '{-99, -99, -99, -99};
      allPre = 1'b0;
      modeOk = 1'b0;
      isOpen = 4'h0;
      slotVal = 8'h0;
      refCnt = 0;
      badCnt = 0;
      dataOut <= 16'h0;
    end
    else
    begin
      cyc++;
      cl = modeOk ? int'(modeReg[6:4]) : 3;
      cmd = chipSel_b ? CMD_NOP : {1'b0, rowStrobe_b, colStrobe_b, writeEn_b};
      key = {bank, openRow[bank], 2'b00, addr[9:0]};
      if (cyc < POWERUP && (cmd != CMD_NOP || !mask || !clkEn))
        fail("power-up wait");
      if (cmd != CMD_NOP && cyc - modeAt < 2)
        fail("mode load spacing");
      case (cmd)
        CMD_PRECHARGE:
        begin
          if (cyc - lastWr < 2)
            fail("write to precharge");
          for (int b = 0; b < 4; b++)
            if (isOpen[b] && cyc - lastAct[b] < 7)
              fail("active to precharge");
          for (int k = cl - 1; k < 8; k++)
            slotVal[(cyc + k) % 8] = 1'b0;
          if (addr[10])
            isOpen = 4'h0;
          else
            isOpen[bank] = 1'b0;
          allPre = addr[10] || allPre;
          lastPre = cyc;
        end
        CMD_REFRESH:
        begin
          if (!allPre || |isOpen || cyc - lastRef < 10)
            fail("refresh");
          refCnt++;
          lastRef = cyc;
        end
        CMD_LOAD_MODE:
        begin
          if (refCnt < 8 || |isOpen)
            fail("mode load");
          modeReg = addr;
          modeOk = 1'b1;
          modeAt = cyc;
        end
        CMD_ACTIVE:
        begin
          if (!modeOk || isOpen[bank] || cyc - lastPre < 3)
            fail("active");
          if (cyc - lastAct[bank] < 10 || cyc - lastActAny < 2)
            fail("active spacing");
          isOpen[bank] = 1'b1;
          openRow[bank] = addr;
          lastAct[bank] = cyc;
          lastActAny = cyc;
        end
        CMD_READ, CMD_WRITE:
        begin
          if (!isOpen[bank] || cyc - lastAct[bank] < 3)
            fail("column command");
          if (cmd == CMD_WRITE)
          begin
            lastWr = cyc;
            if (dataOe_b)
              fail("write without data");
            if (!mask)
              mem[key] = dataIn;
          end
          else
          begin
            slotData[(cyc + cl - 1) % 8] = mem.exists(key) ? mem[key] : 16'hdead;
            slotVal[(cyc + cl - 1) % 8] = 1'b1;
            if (addr[10])
            begin
              isOpen[bank] = 1'b0;
              lastPre = cyc + cl - ((cl == 3) ? 2 : 1);
            end
          end
        end
        CMD_BURST_STOP:
        begin
          for (int k = cl - 1; k < 8; k++)
            slotVal[(cyc + k) % 8] = 1'b0;
        end
        default:
        begin
        end
      endcase
      // a word is driven for one cycle only; a released bus has no pull, so flip it
      if (slotVal[cyc % 8] && !maskPrev)
        dataOut <= slotData[cyc % 8];
      else
        dataOut <= ~dataOut;
      slotVal[cyc % 8] = 1'b0;
      maskPrev = mask;
    end
  end
endmodule

// File: bench/tb_top.sv
// self-checking bench: apb traffic into the controller, device model on its pins
`timescale 1ns/1ps
module tb_top
  import sdc_pkg::*;
;
  localparam int PU = 20;
  localparam int LIMIT = 12000;
  localparam int NACC = 12;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd, r;
  logic pready, pslverr, err;
  logic sdClkEn, sdChipSel_b, sdRowStrobe_b, sdColStrobe_b, sdWriteEn_b, sdMask, sdDataOe_b;
  logic [1:0] sdBank;
  logic [12:0] sdAddr, modeReg;
  logic [15:0] sdDataOut, sdDataIn;
  logic [26:0] addrs [NACC];
  logic [15:0] expMem [logic [26:0]];
  int fails = 0;
  int checks_done = 0;
  int cycles = 0;
  int seed = 32'hc7cfe02a;
  int badCnt, refCnt, refBefore;

  sdc_host #(.DATA_WIDTH(16), .POWERUP_CYCLES(PU)) i_sdc_host (.clk(clk), .rst_b(rst_b),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sdClkEn_q(sdClkEn),
    .sdChipSel_b_q(sdChipSel_b), .sdRowStrobe_b_q(sdRowStrobe_b),
    .sdColStrobe_b_q(sdColStrobe_b), .sdWriteEn_b_q(sdWriteEn_b), .sdBank_q(sdBank),
    .sdAddr_q(sdAddr), .sdMask_q(sdMask), .sdDataIn(sdDataIn), .sdDataOut_q(sdDataOut),
    .sdDataOe_b_q(sdDataOe_b));

  sdc_sdram_model #(.POWERUP(PU)) i_sdc_sdram_model (.clk(clk), .rst_b(rst_b),
    .clkEn(sdClkEn), .chipSel_b(sdChipSel_b), .rowStrobe_b(sdRowStrobe_b),
    .colStrobe_b(sdColStrobe_b), .writeEn_b(sdWriteEn_b), .bank(sdBank), .addr(sdAddr),
    .mask(sdMask), .dataIn(sdDataOut), .dataOe_b(sdDataOe_b), .dataOut(sdDataIn),
    .badCnt(badCnt), .refCnt(refCnt), .modeReg(modeReg));

  // 10 MHz clock and a cycle ceiling that cuts a hang short
  always #50 clk = ~clk;
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      fails++;
      give_verdict();
    end
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic doReset();
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
  endtask

  task automatic waitReady();
    do
      apb(1'b0, REG_STATUS, 32'h0);
    while (rd[2] !== 1'b1);
  endtask

  // start one access and poll until go and busy have both cleared
  task automatic access(input logic wr, input logic [26:0] a, input logic [15:0] d);
    apb(1'b1, REG_ADDR, {5'h0, a});
    if (wr)
      apb(1'b1, REG_WDATA, {16'h0, d});
    apb(1'b1, REG_CTRL, {30'h0, wr, 1'b1});
    do
      apb(1'b0, REG_STATUS, 32'h0);
    while (rd[1:0] !== 2'b00);
  endtask

  task automatic readBack(input logic [26:0] a);
    access(1'b0, a, 16'h0);
    apb(1'b0, REG_RDATA, 32'h0);
    check("read data", rd, {16'h0, expMem[a]});
  endtask

  initial
  begin
    doReset();
    apb(1'b0, REG_STATUS, 32'h0);
    check("status during power-up", rd & 32'h4, 32'h0);
    waitReady();
    apb(1'b0, REG_MODE, 32'h0);
    check("mode register", rd, {19'h0, MODE_RESET});
    check("mode loaded", {19'h0, modeReg}, {19'h0, MODE_RESET});
    check("init refreshes", {31'h0, refCnt >= INIT_REFRESHES}, 32'h1);
    // unmapped and unaligned offsets, read and write
    for (int i = 0; i < 4; i++)
    begin
      apb(i[0], (i < 2) ? 8'h18 : 8'h06, 32'hffffffff);
      check("refused flag", {31'h0, err}, 32'h1);
      check("refused data", i[0] ? 32'h0 : rd, 32'h0);
    end
    $display("registers done");
    // random traffic; the last write overwrites the first location
    for (int i = 0; i < NACC; i++)
    begin
      r = $random(seed);
      addrs[i] = (i == NACC - 1) ? addrs[0] : {r[26:12], 2'b00, r[9:0]};
      r = $random(seed);
      expMem[addrs[i]] = r[15:0];
      access(1'b1, addrs[i], r[15:0]);
    end
    for (int i = 0; i < NACC; i++)
      readBack(addrs[i]);
    $display("traffic done");
    refBefore = refCnt;
    repeat (200) @(posedge clk);
    check("idle refreshes", {31'h0, refCnt - refBefore >= 2}, 32'h1);
    $display("refresh done");
    // the device model forgets its fault count at reset, so take it now
    check("timing faults before reset", badCnt, 32'h0);
    // second reset in mid-run: full init again, stored data survives
    doReset();
    waitReady();
    readBack(addrs[1]);
    check("timing faults", badCnt, 32'h0);
    $display("reset done");
    give_verdict();
  end
endmodule
